// File: oaf_fetch.sv
// Operand fetch sequencer and effective-address formation
//
// Summary of operation
// RL1: Opcode byte then zero, one or two operands
// RL2: PC steps past opcode before operand fetch
// RL3: Inherent forms no address, no operand access
// RL4: Inherent instructions are one byte long
// RL5: Immediate address is byte after opcode
// RL6: Immediate instructions are two bytes long
// RL7: Immediate allowed for all register/memory opcodes
// RL8: Extended address is first:second byte, PC+2
// RL9: Extended is three bytes, reaches all memory
// RL10: Extended allowed for all register/memory opcodes
// RL11: Direct forces high byte zero, two bytes
// RL12: Direct allowed for RMW, reg/mem, bit classes; bit classes decode as BSC/BTB here, forming no address
// RL13: Accumulator operand implied, needs no address
// RL14: Seven mode families, indexed three, bit two
// RL15: Modes expand instructions to 207 or 209 operations
// RL16: Decoder gives mode and operand byte count
`timescale 1ns/1ps
`include "oaf_defines.svh"
module oaf_fetch
  import oaf_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic exec_done_in,
  input wire logic pc_load_in,
  input wire logic [15:0] pc_load_value_in,
  output logic [15:0] mem_addr_out,
  output logic mem_rd_out,
  output oaf_instr_type instr_out,
  output logic instr_valid_out,
  output logic busy_out
);
  // Sequencer states, Gray coded along the fetch path
  typedef enum logic [2:0] {
    OAF_ST_START = 3'b000,
    OAF_ST_OPCODE = 3'b001,
    OAF_ST_BYTE1 = 3'b011,
    OAF_ST_BYTE2 = 3'b010,
    OAF_ST_HOLD = 3'b110
  } oaf_state_type;

  oaf_state_type state_q; // Current sequencer state
  oaf_state_type state_d; // Next sequencer state
  logic [15:0] pc_q; // Program counter
  logic [15:0] pc_d; // Its next value
  logic [15:0] addr_q; // Memory address driven out
  logic [15:0] addr_d; // Its next value
  logic rd_q; // Memory read strobe
  logic rd_d; // Its next value
  oaf_instr_type instr_q; // Instruction being assembled
  oaf_instr_type instr_d; // Its next value
  logic valid_q; // One-cycle ready pulse
  logic valid_d; // Its next value
  oaf_decode_type dec; // Decoder answer for the incoming opcode

  // Decoder looks at the bus byte directly so the count is known in the opcode cycle
  oaf_decoder u_decoder (
    .opcode_in(mem_rdata_in),
    .decode_out(dec)
  );

  // PC plus one, cut to width on purpose; wraps at the top of memory
  wire [15:0] pc_inc = 16'(pc_q + 16'h0001);
  // Next instruction begins at the loaded value on a taken jump, else at the PC
  wire [15:0] resume_pc = pc_load_in ? pc_load_value_in : pc_q;
  // Opcode cycle decisions
  wire op_has_operand = (dec.count != `OAF_COUNT_NONE); // RL1
  // Byte-one cycle decisions
  wire b1_needs_second = (instr_q.count == `OAF_COUNT_TWO);
  wire mode_imm = (instr_q.mode == OAF_MODE_IMM);
  wire mode_dir = (instr_q.mode == OAF_MODE_DIR);
  wire mode_ext = (instr_q.mode == OAF_MODE_EXT);
  // Immediate: the address of the data byte, which is the PC before its step
  wire [15:0] ea_imm = pc_q; // RL5
  // Direct: page zero, high half forced to zero
  wire [15:0] ea_dir = {`OAF_PAGE_ZERO_HIGH, mem_rdata_in}; // RL11
  // Extended: first byte high half, second byte low half
  wire [15:0] ea_ext = {instr_q.byte1, mem_rdata_in}; // RL8
  // Byte-one address choice; extended waits for its second byte
  wire [15:0] ea_after_b1 = mode_imm ? ea_imm : ea_dir;
  wire ea_ok_after_b1 = mode_imm | mode_dir;

  // Next-state and datapath selection
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    addr_d = addr_q;
    rd_d = 1'b0;
    instr_d = instr_q;
    valid_d = 1'b0;
    unique case (state_q)
      OAF_ST_START: begin
        // Leave reset by asking for the first opcode
        addr_d = pc_q;
        rd_d = 1'b1;
        state_d = OAF_ST_OPCODE;
      end
      OAF_ST_OPCODE: begin
        // Capture opcode and step past it before any operand read
        instr_d = '0;
        instr_d.opcode = mem_rdata_in;
        instr_d.mode = dec.mode; // RL16
        instr_d.count = dec.count; // RL16
        pc_d = pc_inc; // RL2
        instr_d.next_pc = pc_inc;
        if (op_has_operand) begin
          addr_d = pc_inc; // RL2
          rd_d = 1'b1;
          state_d = OAF_ST_BYTE1;
        end else begin
          // Inherent and no-offset indexed: nothing more to read
          state_d = OAF_ST_HOLD; // RL3 RL4
          valid_d = 1'b1;
        end
      end
      OAF_ST_BYTE1: begin
        // First operand byte; PC steps once more
        instr_d.byte1 = mem_rdata_in;
        pc_d = pc_inc; // RL5 RL6
        instr_d.next_pc = pc_inc;
        if (b1_needs_second) begin
          addr_d = pc_inc;
          rd_d = 1'b1;
          state_d = OAF_ST_BYTE2;
        end else begin
          // Modes that form no address here leave it at zero
          instr_d.effective_address = ea_ok_after_b1 ? ea_after_b1 : 16'h0000; // RL11
          instr_d.ea_valid = ea_ok_after_b1;
          state_d = OAF_ST_HOLD; // RL6
          valid_d = 1'b1;
        end
      end
      OAF_ST_BYTE2: begin
        // Second operand byte; two steps in total past the opcode
        instr_d.byte2 = mem_rdata_in;
        pc_d = pc_inc; // RL8
        instr_d.next_pc = pc_inc;
        // Full 16-bit reach, so any of I/O, RAM or ROM may be addressed
        instr_d.effective_address = mode_ext ? ea_ext : 16'h0000; // RL9
        instr_d.ea_valid = mode_ext; // RL9
        state_d = OAF_ST_HOLD;
        valid_d = 1'b1;
      end
      OAF_ST_HOLD: begin
        // Instruction stands until execution finishes; accumulator needs no address
        if (exec_done_in) begin // RL13
          pc_d = resume_pc;
          addr_d = resume_pc;
          rd_d = 1'b1;
          state_d = OAF_ST_OPCODE;
        end
      end
      default: begin
        // Unused codes recover by refetching at the PC
        state_d = OAF_ST_START;
      end
    endcase
  end

  // State registers; the clock enable freezes everything
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= OAF_ST_START;
      pc_q <= `OAF_PC_RESET;
      addr_q <= `OAF_PC_RESET;
      rd_q <= 1'b0;
      instr_q <= '0;
      valid_q <= 1'b0;
    end else if (ce_in) begin
      state_q <= state_d;
      pc_q <= pc_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      instr_q <= instr_d;
      valid_q <= valid_d;
    end
  end

  // Busy flag registered so every output leaves a flip-flop
  logic busy_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_q <= 1'b1;
    end else if (ce_in) begin
      busy_q <= (state_d != OAF_ST_HOLD);
    end
  end

  // Outputs come straight from registers
  assign mem_addr_out = addr_q;
  assign mem_rd_out = rd_q;
  assign instr_out = instr_q;
  assign instr_valid_out = valid_q;
  assign busy_out = busy_q;
endmodule : oaf_fetch

// File: oaf_defines.svh
// Constants for operand fetch and effective-address formation
`ifndef OAF_DEFINES_SVH
`define OAF_DEFINES_SVH
`define OAF_PC_RESET 16'h0000
`define OAF_PAGE_ZERO_HIGH 8'h00
`define OAF_COUNT_NONE 2'h0
`define OAF_COUNT_ONE 2'h1
`define OAF_COUNT_TWO 2'h2
`define OAF_NIB_BTB 4'h0
`define OAF_NIB_BSC 4'h1
`define OAF_NIB_REL 4'h2
`define OAF_NIB_RMW_DIR 4'h3
`define OAF_NIB_RMW_A 4'h4
`define OAF_NIB_RMW_X 4'h5
`define OAF_NIB_RMW_IX1 4'h6
`define OAF_NIB_RMW_IX0 4'h7
`define OAF_NIB_CTL_A 4'h8
`define OAF_NIB_CTL_B 4'h9
`define OAF_NIB_RM_IMM 4'hA
`define OAF_NIB_RM_DIR 4'hB
`define OAF_NIB_RM_EXT 4'hC
`define OAF_NIB_RM_IX2 4'hD
`define OAF_NIB_RM_IX1 4'hE
`define OAF_NIB_RM_IX0 4'hF
`endif

// File: oaf_pkg.sv
// Types shared by the opcode decoder and the operand fetch sequencer
package oaf_pkg;
  // Addressing-mode families, indexed and bit variants spelled out
  typedef enum logic [3:0] {
    OAF_MODE_INH = 4'h0,
    OAF_MODE_IMM = 4'h1,
    OAF_MODE_DIR = 4'h2,
    OAF_MODE_EXT = 4'h3,
    OAF_MODE_IX0 = 4'h4,
    OAF_MODE_IX1 = 4'h5,
    OAF_MODE_IX2 = 4'h6,
    OAF_MODE_REL = 4'h7,
    OAF_MODE_BSC = 4'h8,
    OAF_MODE_BTB = 4'h9
  } oaf_mode_type;

  // Decoder answer for one opcode
  typedef struct packed {
    oaf_mode_type mode;
    logic [1:0] count;
  } oaf_decode_type;

  // Instruction handed to the execution unit
  typedef struct packed {
    logic [7:0] opcode;
    oaf_mode_type mode;
    logic [1:0] count;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [15:0] effective_address;
    logic ea_valid;
    logic [15:0] next_pc;
  } oaf_instr_type;
endpackage : oaf_pkg

// File: oaf_decoder.sv
// Opcode to addressing-mode and operand byte count decoder
`timescale 1ns/1ps
`include "oaf_defines.svh"
module oaf_decoder
  import oaf_pkg::*;
(
  input wire logic [7:0] opcode_in,
  output oaf_decode_type decode_out
);
  // Upper nibble selects the class column of the opcode map
  wire [3:0] column = opcode_in[7:4];

  // Column decode; every register/memory column gets its own mode
  always_comb begin // RL15
    decode_out = '{mode: OAF_MODE_INH, count: `OAF_COUNT_NONE};
    unique case (column)
      `OAF_NIB_BTB: decode_out = '{mode: OAF_MODE_BTB, count: `OAF_COUNT_TWO}; // RL14
      `OAF_NIB_BSC: decode_out = '{mode: OAF_MODE_BSC, count: `OAF_COUNT_ONE}; // RL14
      `OAF_NIB_REL: decode_out = '{mode: OAF_MODE_REL, count: `OAF_COUNT_ONE}; // RL14
      `OAF_NIB_RMW_DIR: decode_out = '{mode: OAF_MODE_DIR, count: `OAF_COUNT_ONE}; // RL12
      `OAF_NIB_RMW_A,
      `OAF_NIB_RMW_X,
      `OAF_NIB_CTL_A,
      `OAF_NIB_CTL_B: decode_out = '{mode: OAF_MODE_INH, count: `OAF_COUNT_NONE}; // RL4
      `OAF_NIB_RMW_IX1: decode_out = '{mode: OAF_MODE_IX1, count: `OAF_COUNT_ONE};
      `OAF_NIB_RMW_IX0: decode_out = '{mode: OAF_MODE_IX0, count: `OAF_COUNT_NONE};
      `OAF_NIB_RM_IMM: decode_out = '{mode: OAF_MODE_IMM, count: `OAF_COUNT_ONE}; // RL7
      `OAF_NIB_RM_DIR: decode_out = '{mode: OAF_MODE_DIR, count: `OAF_COUNT_ONE}; // RL12
      `OAF_NIB_RM_EXT: decode_out = '{mode: OAF_MODE_EXT, count: `OAF_COUNT_TWO}; // RL10
      `OAF_NIB_RM_IX2: decode_out = '{mode: OAF_MODE_IX2, count: `OAF_COUNT_TWO};
      `OAF_NIB_RM_IX1: decode_out = '{mode: OAF_MODE_IX1, count: `OAF_COUNT_ONE};
      `OAF_NIB_RM_IX0: decode_out = '{mode: OAF_MODE_IX0, count: `OAF_COUNT_NONE};
    endcase
  end
endmodule : oaf_decoder

// File: oaf_mem_model.sv
// Byte-wide memory answering each read in the same cycle as its strobe
`timescale 1ns/1ps
module oaf_mem_model (
  input wire logic clk_in,
  input wire logic mem_rd_in,
  input wire logic [15:0] mem_addr_in,
  output logic [7:0] mem_rdata_out
);
  logic [7:0] mem [0:65535]; // Whole space, filled by the bench
  int reads = 0; // Reads seen, used for fetch length checks
  initial mem_rdata_out = 8'h00;
  // Strobe and address are taken once they have left the edge, so the byte stands
  // through the cycle in which the strobe is high and is sampled at its end
  // Otherwise the bus flips so stale data never looks valid
  always @(posedge clk_in) begin
    #1;
    if (mem_rd_in) begin
      reads++;
      mem_rdata_out = mem[mem_addr_in];
    end else begin
      mem_rdata_out = ~mem_rdata_out;
    end
  end
endmodule : oaf_mem_model

// File: oaf_fetch_chk.sv
// Port assertions for the operand fetch sequencer
`timescale 1ns/1ps
module oaf_fetch_chk
  import oaf_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic exec_done_in,
  input wire logic pc_load_in,
  input wire logic [15:0] pc_load_value_in,
  input wire logic [15:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire oaf_instr_type instr_out,
  input wire logic instr_valid_out,
  input wire logic busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Hand-back steps of the execution side, and two back-to-back memory reads
  sequence s_done_seq;
    !busy_out && exec_done_in && !pc_load_in;
  endsequence
  sequence s_done_jump;
    !busy_out && exec_done_in && pc_load_in;
  endsequence
  sequence s_two_reads;
    mem_rd_out ##1 mem_rd_out;
  endsequence
  chk_next_seq: assert property (s_done_seq |=>
    mem_rd_out && mem_addr_out == $past(instr_out.next_pc)) else $error("bad next opcode");
  chk_next_jump: assert property (s_done_jump |=>
    mem_rd_out && mem_addr_out == $past(pc_load_value_in)) else $error("bad jump fetch");
  chk_hold_stable: assert property (!busy_out && !exec_done_in |=>
    $stable(instr_out) && !mem_rd_out) else $error("hold not stable");
  chk_valid_pulse: assert property (instr_valid_out |->
    !busy_out ##1 !instr_valid_out) else $error("valid not a pulse");
  chk_addr_step: assert property (s_two_reads |->
    mem_addr_out == $past(mem_addr_out) + 16'h0001) else $error("read order");
  chk_inh_form: assert property (instr_valid_out && instr_out.mode == OAF_MODE_INH |->
    instr_out.count == 2'h0 && !instr_out.ea_valid) else $error("inherent form");
  chk_imm_form: assert property (instr_valid_out && instr_out.mode == OAF_MODE_IMM |->
    instr_out.count == 2'h1 && instr_out.effective_address == instr_out.next_pc - 16'h0001)
    else $error("immediate form");
  chk_ext_form: assert property (instr_valid_out && instr_out.mode == OAF_MODE_EXT |->
    instr_out.count == 2'h2 && instr_out.effective_address == {instr_out.byte1, instr_out.byte2})
    else $error("extended form");
  chk_dir_form: assert property (instr_valid_out && instr_out.mode == OAF_MODE_DIR |->
    instr_out.count == 2'h1 && instr_out.effective_address == {8'h00, instr_out.byte1})
    else $error("direct form");
  chk_ce_freeze: assert property (!ce_in |=>
    $stable(instr_out) && $stable(mem_addr_out) && $stable(mem_rd_out) && $stable(busy_out))
    else $error("clock enable did not freeze");
endmodule : oaf_fetch_chk
bind oaf_fetch oaf_fetch_chk u_oaf_fetch_chk (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .mem_rdata_in(mem_rdata_in), .exec_done_in(exec_done_in), .pc_load_in(pc_load_in),
  .pc_load_value_in(pc_load_value_in), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
  .instr_out(instr_out), .instr_valid_out(instr_valid_out), .busy_out(busy_out));

// File: tb.sv
// Self-checking bench for the operand fetch sequencer
`timescale 1ns/1ps
module tb;
  import oaf_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, exec_done_in = 1'b0, pc_load_in = 1'b0;
  logic [15:0] pc_load_value_in = 16'h0000;
  logic [7:0] mem_rdata_in;
  logic [15:0] mem_addr_out;
  logic mem_rd_out, instr_valid_out, busy_out;
  oaf_instr_type instr_out, e, g;
  oaf_instr_type exp_q[$]; // Expected instructions, oldest first
  int failures = 0, tests_run = 0, last_reads = 0;
  logic [31:0] seed = 32'hc47e;
  oaf_fetch u_oaf_fetch (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .mem_rdata_in(mem_rdata_in), .exec_done_in(exec_done_in), .pc_load_in(pc_load_in),
    .pc_load_value_in(pc_load_value_in), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
    .instr_out(instr_out), .instr_valid_out(instr_valid_out), .busy_out(busy_out));
  oaf_mem_model u_oaf_mem_model (.clk_in(clk_in), .mem_rd_in(mem_rd_out),
    .mem_addr_in(mem_addr_out), .mem_rdata_out(mem_rdata_in));
  initial forever #12.5 clk_in = ~clk_in;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want) begin
      failures++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic complete_run;
    $display("Counts: %0d compared, %0d mismatched", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // Random instruction at a: any class column, any low nibble, per the opcode map
  task automatic place(input logic [15:0] a);
    logic [3:0] k;
    oaf_mode_type modes [16];
    logic [1:0] counts [16];
    modes = '{OAF_MODE_BTB, OAF_MODE_BSC, OAF_MODE_REL, OAF_MODE_DIR, OAF_MODE_INH, OAF_MODE_INH,
      OAF_MODE_IX1, OAF_MODE_IX0, OAF_MODE_INH, OAF_MODE_INH, OAF_MODE_IMM, OAF_MODE_DIR,
      OAF_MODE_EXT, OAF_MODE_IX2, OAF_MODE_IX1, OAF_MODE_IX0};
    counts = '{2'h2, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2,
      2'h1, 2'h0};
    seed = xs(seed);
    k = seed[3:0];
    e = '0;
    e.opcode = {k, seed[11:8]};
    e.byte1 = seed[23:16];
    e.byte2 = seed[31:24];
    u_oaf_mem_model.mem[a] = e.opcode;
    u_oaf_mem_model.mem[a + 16'h0001] = e.byte1;
    u_oaf_mem_model.mem[a + 16'h0002] = e.byte2;
    e.mode = modes[k];
    e.count = counts[k];
    // Only immediate, direct and extended form an address; the rest leave it at zero
    e.ea_valid = (e.mode == OAF_MODE_IMM) || (e.mode == OAF_MODE_DIR) || (e.mode == OAF_MODE_EXT);
    e.effective_address = e.mode == OAF_MODE_IMM ? a + 16'h0001 : e.mode == OAF_MODE_EXT ?
      {e.byte1, e.byte2} : e.mode == OAF_MODE_DIR ? {8'h00, e.byte1} : 16'h0000;
    e.next_pc = a + 16'h0001 + 16'(e.count);
    exp_q.push_back(e);
  endtask : place
  // Wait for an instruction to stand; a limit that runs out is a mismatch
  task automatic wait_idle;
    for (int w = 0; w < 20 && busy_out !== 1'b0; w++) @(posedge clk_in) #2;
    check(16'(busy_out), 16'h0000);
  endtask : wait_idle
  // Monitor: each valid pulse is matched with the oldest note
  always @(posedge clk_in) begin
    if (instr_valid_out === 1'b1) begin
      g = exp_q.pop_front();
      check(instr_out.opcode, g.opcode);
      check(instr_out.mode, g.mode);
      check(instr_out.count, g.count);
      check(instr_out.ea_valid, g.ea_valid);
      check(instr_out.effective_address, g.effective_address);
      check(instr_out.next_pc, g.next_pc);
      check(16'(u_oaf_mem_model.reads - last_reads), 16'h0001 + 16'(g.count));
      last_reads = u_oaf_mem_model.reads;
    end
  end
  // Main sequence: jumps and fall-through alternate at random
  initial begin
    place(16'h0000);
    repeat (2) @(posedge clk_in);
    #2 rst_in = 1'b0;
    for (int n = 0; n < 60; n++) begin
      @(posedge clk_in) #2;
      wait_idle();
      seed = xs(seed);
      pc_load_in = seed[0];
      pc_load_value_in = seed[15:0] & 16'hfff0;
      // Now and then freeze the held instruction once its valid pulse has passed
      if (seed[1]) begin
        @(posedge clk_in) #2;
        ce_in = 1'b0;
        @(posedge clk_in) #2;
        ce_in = 1'b1;
      end
      place(pc_load_in ? pc_load_value_in : e.next_pc);
      exec_done_in = 1'b1;
      @(posedge clk_in) #2;
      exec_done_in = 1'b0;
      pc_load_in = 1'b0;
      $display("test %0d done", n);
    end
    wait_idle();
    @(posedge clk_in) #2;
    // The last valid pulse has been matched, so every note is used up
    check(16'(exp_q.size()), 16'h0000);
    complete_run();
  end
  // Watchdog well beyond the longest run
  initial begin
    #100000;
    failures++;
    complete_run();
  end
endmodule : tb
